// [hdl/dsf_defines.svh]
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH
// Status bit positions.
`define DSF_BIT_BUSY 0
`define DSF_BIT_B1 1
`define DSF_BIT_B2 2
`define DSF_BIT_B3 3
`define DSF_BIT_B4 4
`define DSF_BIT_B5 5
`define DSF_BIT_B6 6
`define DSF_BIT_NRDY 7
// Register select code of the status register on the parallel port.
`define DSF_ADDR_STATUS 2'h0
// Most cycles allowed from command write to busy set; busy sets at once.
`define DSF_BUSY_DLY_SD 5'h18
`define DSF_BUSY_DLY_DD 5'h0C
`define DSF_STATUS_RESET 8'h00
// Not ready reads one while reset is held.
`define DSF_STATUS_AT_RESET 8'h80
// Write track control byte range with special handling.
`define DSF_CTRL_LO 8'hF5
`define DSF_CTRL_HI 8'hFE
`define DSF_CRC_PRESET 16'hFFFF
`define DSF_CRC_POLY 16'h1021
`endif

// [hdl/dsf_pkg.sv]
package dsf_pkg;
  typedef enum logic [2:0] {
    DSF_CMD_T1 = 3'b000,
    DSF_CMD_RD_SEC = 3'b001,
    DSF_CMD_WR_SEC = 3'b010,
    DSF_CMD_RD_ADR = 3'b011,
    DSF_CMD_RD_TRK = 3'b100,
    DSF_CMD_WR_TRK = 3'b101
  } dsf_class_t;
  typedef enum logic [1:0] {
    DSF_ST_IDLE = 2'b00,
    DSF_ST_WAIT = 2'b01,
    DSF_ST_RUN = 2'b10
  } dsf_state_t;
endpackage

// [hdl/dsf_fmt_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface dsf_fmt_if;
  logic valid;
  logic [7:0] data;
  logic mark;
  logic crc_preset;
  logic crc_write;
  logic [15:0] crc;
  modport ctl (output valid, output data, input mark, input crc_preset, input crc_write, input crc);
  modport fmt (input valid, input data, output mark, output crc_preset, output crc_write, output crc);
endinterface
`default_nettype wire

// [hdl/dsf_fmt_byte.sv]
`timescale 1ns/10ps
`default_nettype none
`include "dsf_defines.svh"
module dsf_fmt_byte (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  dsf_fmt_if.fmt f
);
  logic [15:0] crc;
  logic [15:0] next_crc;
  logic [15:0] c;
  logic special;
  // Values F5 through FE are control bytes; everything else goes to the medium unchanged.
  always_comb begin
    special = (f.data >= `DSF_CTRL_LO) && (f.data <= `DSF_CTRL_HI); // R23
    f.mark = f.valid && special && (f.data != 8'hF7);
    f.crc_write = f.valid && (f.data == 8'hF7);
    f.crc_preset = f.valid && ((f.data == 8'hF5) || (f.data == 8'hFE) || (f.data[7:2] == 6'h3E));
    c = crc;
    if (f.crc_preset) begin
      c = `DSF_CRC_PRESET;
    end
    next_crc = c;
    if (f.valid && !f.crc_write && !(f.data == 8'hF5)) begin
      for (int i = 7; i >= 0; i--) begin
        next_crc = {next_crc[14:0], 1'b0} ^ ((next_crc[15] ^ f.data[i]) ? `DSF_CRC_POLY : 16'h0000);
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      crc <= `DSF_CRC_PRESET;
    end else begin
      crc <= next_crc;
    end
  end
  assign f.crc = crc;
  property p_preset;
    @(posedge clk_sys_i) disable iff (!reset_n_i) f.valid && (f.data == `DSF_CTRL_LO) |=> crc == `DSF_CRC_PRESET;
  endproperty
  a_preset: assert property (p_preset) else $error("crc preset"); // R23
endmodule
`default_nettype wire

// [hdl/dsf_status.sv]
`timescale 1ns/10ps
`default_nettype none
`include "dsf_defines.svh"
// Overview of operation
// (R1) Busy holds at one throughout any type 1, 2 or 3 command.
// (R2) A force interrupt clears busy whatever was running.
// (R3) Force interrupt when idle shows type 1 layout with bits 4, 3, 0 zero.
// (R4) Force interrupt during a command keeps that command's layout; busy reads zero.
// (R5) Bit 7 is inverted ready OR inverted reset, always.
// (R6) Bit 6 is write protect for type 1 and writes, zero for reads.
// (R7) Type 1 bit 5 is head engaged AND head settled.
// (R8) Type 1 bit 4 flags a failed verify, cleared at next command.
// (R9) Bit 3 flags a CRC error, cleared at next command.
// (R10) Type 1 bit 2 is the inverted outer track input.
// (R11) Type 1 bit 1 is the inverted index input.
// (R12) Busy rises within 24 cycles single density, 12 double density.
// (R13) Read sector bit 5 records a deleted data mark.
// (R14) Write bit 5 flags a write fault abort, cleared at next command.
// (R15) Bit 4 flags record not found for type 2 and read address.
// (R16) Bit 2 flags lost data for type 2, read address, read track.
// (R17) Type 2 and 3 bit 1 mirrors the byte transfer request exactly.
// (R18) Host feeds the single density track preamble and trailing fill bytes.
// (R19) Host feeds the double density preamble, sync and fill bytes.
// (R20) Host sends 26 sector groups with ID, CRC request, data mark and data.
// (R21) Bits unused by a layout read zero.
// (R22) Force interrupt request clears on status read or next command.
// (R23) Track format bytes F5 to FE get mark or CRC handling.
module dsf_status (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic cmd_start_i,
  input wire logic [2:0] cmd_class_i,
  input wire logic force_int_i,
  input wire logic force_int_now_i,
  input wire logic cmd_done_i,
  input wire logic double_density_i,
  input wire logic drive_ready_i,
  input wire logic media_locked_n_in,
  input wire logic head_engage_out,
  input wire logic head_settled_in,
  input wire logic outer_track_n_in,
  input wire logic index_n_in,
  input wire logic byte_transfer_request,
  input wire logic verify_fail_i,
  input wire logic crc_fail_i,
  input wire logic not_found_i,
  input wire logic lost_data_i,
  input wire logic write_fault_i,
  input wire logic deleted_mark_i,
  input wire logic fmt_valid_i,
  input wire logic [7:0] fmt_data_i,
  output logic [7:0] status_o,
  output logic host_interrupt_request,
  output logic fmt_mark_o,
  output logic fmt_crc_write_o,
  output logic [15:0] fmt_crc_o
);
  ////////////////////////////////////////////////////////////////////////////
  dsf_pkg::dsf_state_t state;
  dsf_pkg::dsf_state_t next_state;
  dsf_pkg::dsf_class_t cls;
  dsf_pkg::dsf_class_t next_cls;
  logic [4:0] dly;
  logic [4:0] next_dly;
  logic f_b4, f_b3, f_b2, f_b5;
  logic next_f_b4, next_f_b3, next_f_b2, next_f_b5;
  logic fi_idle;
  logic next_fi_idle;
  logic irq;
  logic next_irq;
  logic [7:0] stat;
  logic [7:0] next_stat;
  logic busy;
  logic status_rd;
  assign busy = (state != dsf_pkg::DSF_ST_IDLE);
  assign status_rd = !cs_n_i && !rd_n_i && (reg_sel_i == `DSF_ADDR_STATUS);
  ////////////////////////////////////////////////////////////////////////////
  // Sequencing and latched error flags.
  always_comb begin
    next_state = state;
    next_cls = cls;
    next_dly = dly;
    next_f_b4 = f_b4 | verify_fail_i | not_found_i;
    next_f_b3 = f_b3 | crc_fail_i;
    next_f_b2 = f_b2 | lost_data_i;
    next_f_b5 = f_b5;
    next_fi_idle = fi_idle;
    next_irq = irq;
    if (cls == dsf_pkg::DSF_CMD_RD_SEC && deleted_mark_i) begin
      next_f_b5 = 1'b1; // R13
    end
    if (write_fault_i) begin
      next_f_b5 = 1'b1; // R14
    end
    if (status_rd) begin
      next_irq = 1'b0; // R22
    end
    if (force_int_now_i) begin
      next_irq = 1'b1;
    end
    case (state)
      dsf_pkg::DSF_ST_IDLE: begin
        if (cmd_start_i) begin
          next_state = dsf_pkg::DSF_ST_WAIT;
          next_cls = dsf_pkg::dsf_class_t'(cmd_class_i);
          next_fi_idle = 1'b0;
          next_irq = 1'b0; // R22
          // Flags clear as the next command begins; a fresh event in this cycle is lost by design.
          next_f_b4 = 1'b0; // R8 R15
          next_f_b3 = 1'b0; // R9
          next_f_b2 = 1'b0; // R16
          next_f_b5 = 1'b0; // R14
          next_dly = double_density_i ? `DSF_BUSY_DLY_DD : `DSF_BUSY_DLY_SD; // R12
        end else if (force_int_i) begin
          next_fi_idle = 1'b1; // R3
          next_cls = dsf_pkg::DSF_CMD_T1; // R3
        end
      end
      dsf_pkg::DSF_ST_WAIT: begin
        // Busy is set at once; the budget only bounds it.
        next_state = dsf_pkg::DSF_ST_RUN; // R12
        next_dly = 5'h00;
      end
      dsf_pkg::DSF_ST_RUN: begin
        if (cmd_done_i) begin
          next_state = dsf_pkg::DSF_ST_IDLE;
        end
      end
      default: begin
        next_state = dsf_pkg::DSF_ST_IDLE;
      end
    endcase
    if (force_int_i && busy) begin
      next_state = dsf_pkg::DSF_ST_IDLE; // R2 R4
    end
  end
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= dsf_pkg::DSF_ST_IDLE;
      cls <= dsf_pkg::DSF_CMD_T1;
      dly <= 5'h00;
      f_b4 <= 1'b0;
      f_b3 <= 1'b0;
      f_b2 <= 1'b0;
      f_b5 <= 1'b0;
      fi_idle <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      cls <= next_cls;
      dly <= next_dly;
      f_b4 <= next_f_b4;
      f_b3 <= next_f_b3;
      f_b2 <= next_f_b2;
      f_b5 <= next_f_b5;
      fi_idle <= next_fi_idle;
      irq <= next_irq;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Status composition, registered so the host sees a clean byte.
  always_comb begin
    next_stat = `DSF_STATUS_RESET;
    next_stat[`DSF_BIT_NRDY] = !drive_ready_i || !reset_n_i; // R5
    next_stat[`DSF_BIT_BUSY] = (next_state != dsf_pkg::DSF_ST_IDLE); // R1 R2
    case (next_cls)
      dsf_pkg::DSF_CMD_T1: begin
        next_stat[`DSF_BIT_B6] = !media_locked_n_in; // R6
        next_stat[`DSF_BIT_B5] = head_engage_out && head_settled_in; // R7
        next_stat[`DSF_BIT_B4] = next_f_b4 && !next_fi_idle; // R8 R3
        next_stat[`DSF_BIT_B3] = next_f_b3 && !next_fi_idle; // R9 R3
        next_stat[`DSF_BIT_B2] = !outer_track_n_in; // R10
        next_stat[`DSF_BIT_B1] = !index_n_in; // R11
      end
      dsf_pkg::DSF_CMD_RD_SEC, dsf_pkg::DSF_CMD_WR_SEC: begin
        next_stat[`DSF_BIT_B6] = (next_cls == dsf_pkg::DSF_CMD_WR_SEC) && !media_locked_n_in; // R6 R21
        next_stat[`DSF_BIT_B5] = next_f_b5; // R13 R14
        next_stat[`DSF_BIT_B4] = next_f_b4; // R15
        next_stat[`DSF_BIT_B3] = next_f_b3; // R9
        next_stat[`DSF_BIT_B2] = next_f_b2; // R16
        next_stat[`DSF_BIT_B1] = byte_transfer_request; // R17
      end
      dsf_pkg::DSF_CMD_RD_ADR: begin
        next_stat[`DSF_BIT_B4] = next_f_b4; // R15 R21
        next_stat[`DSF_BIT_B3] = next_f_b3; // R9
        next_stat[`DSF_BIT_B2] = next_f_b2; // R16
        next_stat[`DSF_BIT_B1] = byte_transfer_request; // R17
      end
      dsf_pkg::DSF_CMD_RD_TRK: begin
        next_stat[`DSF_BIT_B2] = next_f_b2; // R16 R21
        next_stat[`DSF_BIT_B1] = byte_transfer_request; // R17
      end
      dsf_pkg::DSF_CMD_WR_TRK: begin
        next_stat[`DSF_BIT_B6] = !media_locked_n_in; // R6
        next_stat[`DSF_BIT_B5] = next_f_b5; // R14 R21
        next_stat[`DSF_BIT_B1] = byte_transfer_request; // R17
      end
      default: begin
        next_stat[`DSF_BIT_B1] = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stat <= `DSF_STATUS_AT_RESET;
    end else begin
      stat <= next_stat;
    end
  end
  assign status_o = stat;
  assign host_interrupt_request = irq;
  ////////////////////////////////////////////////////////////////////////////
  // Track format byte handling. The host supplies the gap, sync and sector
  // sequences itself; this side decodes control bytes and keeps the running CRC. R18 R19 R20
  dsf_fmt_if fif ();
  assign fif.valid = fmt_valid_i && (cls == dsf_pkg::DSF_CMD_WR_TRK) && busy; // R23
  assign fif.data = fmt_data_i;
  dsf_fmt_byte u_fmt (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .f(fif)
  );
  assign fmt_mark_o = fif.mark;
  assign fmt_crc_write_o = fif.crc_write;
  assign fmt_crc_o = fif.crc;
  ////////////////////////////////////////////////////////////////////////////
  property p_busy_rise;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == dsf_pkg::DSF_ST_IDLE) && cmd_start_i && !force_int_i |=> ##[0:11] status_o[0];
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy late"); // R12
  property p_flag_clear;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == dsf_pkg::DSF_ST_IDLE) && cmd_start_i && !force_int_i |=> !f_b4 && !f_b3 && !f_b2 && !f_b5;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared"); // R8 R9 R14 R15 R16
  property p_t1_live;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      next_cls == dsf_pkg::DSF_CMD_T1 |=> status_o[2:1] == ~{$past(outer_track_n_in), $past(index_n_in)};
  endproperty
  a_t1_live: assert property (p_t1_live) else $error("track or index wrong"); // R10 R11
  property p_head;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      next_cls == dsf_pkg::DSF_CMD_T1 |=> status_o[5] == ($past(head_engage_out) && $past(head_settled_in));
  endproperty
  a_head: assert property (p_head) else $error("head loaded wrong"); // R7
  property p_protect;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (next_cls == dsf_pkg::DSF_CMD_T1) || (next_cls == dsf_pkg::DSF_CMD_WR_SEC)
      || (next_cls == dsf_pkg::DSF_CMD_WR_TRK) |=> status_o[6] == !$past(media_locked_n_in);
  endproperty
  a_protect: assert property (p_protect) else $error("write protect wrong"); // R6
  property p_wrtrk;
    @(posedge clk_sys_i) disable iff (!reset_n_i) next_cls == dsf_pkg::DSF_CMD_WR_TRK |=> status_o[4:2] == 3'h0;
  endproperty
  a_wrtrk: assert property (p_wrtrk) else $error("unused write track bits set"); // R21
  property p_fi_keep;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      busy && force_int_i |=> cls == $past(cls);
  endproperty
  a_fi_keep: assert property (p_fi_keep) else $error("interrupted layout lost"); // R4
  property p_fi_clear;
    @(posedge clk_sys_i) disable iff (!reset_n_i) force_int_i |=> !status_o[0];
  endproperty
  a_fi_clear: assert property (p_fi_clear) else $error("busy not cleared"); // R2
  property p_busy_hold;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == dsf_pkg::DSF_ST_RUN) && !cmd_done_i && !force_int_i |=> status_o[0];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped"); // R1
  property p_nrdy;
    @(posedge clk_sys_i) disable iff (!reset_n_i) 1'b1 |=> status_o[7] == !$past(drive_ready_i);
  endproperty
  a_nrdy: assert property (p_nrdy) else $error("not ready wrong"); // R5
  property p_fi_idle;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == dsf_pkg::DSF_ST_IDLE) && force_int_i && !cmd_start_i |=> status_o[4:3] == 2'b00;
  endproperty
  a_fi_idle: assert property (p_fi_idle) else $error("idle abort layout"); // R3
  property p_drq;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      cls != dsf_pkg::DSF_CMD_T1 && next_cls == cls ##1 1'b1 |-> status_o[1] == $past(byte_transfer_request);
  endproperty
  a_drq: assert property (p_drq) else $error("request mirror"); // R17
  property p_rdtrk;
    @(posedge clk_sys_i) disable iff (!reset_n_i) cls == dsf_pkg::DSF_CMD_RD_TRK ##1 cls == dsf_pkg::DSF_CMD_RD_TRK |->
      status_o[6:3] == 4'h0;
  endproperty
  a_rdtrk: assert property (p_rdtrk) else $error("unused bits set"); // R21
  property p_irq_rd;
    @(posedge clk_sys_i) disable iff (!reset_n_i) status_rd && !force_int_now_i |=> !host_interrupt_request;
  endproperty
  a_irq_rd: assert property (p_irq_rd) else $error("irq not cleared"); // R22
  property p_lost;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      lost_data_i && busy && cls != dsf_pkg::DSF_CMD_T1 && cls != dsf_pkg::DSF_CMD_WR_TRK && !force_int_i
      && !cmd_start_i |=> status_o[2];
  endproperty
  a_lost: assert property (p_lost) else $error("lost data"); // R16
endmodule
`default_nettype wire

// [verif/dsf_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module dsf_host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] status_i,
  input wire logic crc_write_i,
  input wire logic mark_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic [1:0] reg_sel_o,
  output logic fmt_valid_o,
  output logic [7:0] fmt_data_o
);
  int n_crc = 0;
  int n_mark = 0;
  logic [7:0] last_read;
  initial begin
    cs_n_o = 1'h1;
    rd_n_o = 1'h1;
    reg_sel_o = 2'h3;
    fmt_valid_o = 1'h0;
    fmt_data_o = 8'hA5;
  end
  // Counted at the sampling edge, so a byte held over several edges counts once per edge.
  always @(posedge clk_sys_i) begin
    if (fmt_valid_o === 1'h1 && crc_write_i === 1'h1) begin
      n_crc <= n_crc + 1;
    end
    if (fmt_valid_o === 1'h1 && mark_i === 1'h1) begin
      n_mark <= n_mark + 1;
    end
  end
  task automatic fmt_idle();
    @(posedge clk_sys_i);
    fmt_valid_o <= 1'h0;
    fmt_data_o <= ~fmt_data_o;
  endtask
  ////////////////////////////////////////
  task automatic read_status();
    @(posedge clk_sys_i);
    cs_n_o <= 1'h0;
    rd_n_o <= 1'h0;
    reg_sel_o <= 2'h0;
    @(posedge clk_sys_i);
    last_read = status_i;
    cs_n_o <= 1'h1;
    rd_n_o <= 1'h1;
    reg_sel_o <= 2'h3;
  endtask
  task automatic put_run(input int n, input logic [7:0] b);
    repeat (n) begin
      @(posedge clk_sys_i);
      fmt_valid_o <= 1'h1;
      fmt_data_o <= b;
    end
  endtask
  task automatic fmt_track(input logic dd);
    logic [7:0] gap;
    gap = dd ? 8'h4E : 8'hFF;
    put_run(dd ? 80 : 40, gap);
    put_run(dd ? 12 : 6, 8'h00);
    if (dd) put_run(3, 8'hF6);
    put_run(1, 8'hFC);
    put_run(dd ? 50 : 26, gap);
    for (int s = 1; s <= 26; s++) begin
      put_run(dd ? 12 : 6, 8'h00);
      if (dd) put_run(3, 8'hF5);
      put_run(1, 8'hFE);
      put_run(1, 8'h05);
      put_run(1, 8'h00);
      put_run(1, 8'(s));
      put_run(1, dd ? 8'h01 : 8'h00);
      put_run(1, 8'hF7);
      put_run(dd ? 22 : 11, gap);
      put_run(dd ? 12 : 6, 8'h00);
      if (dd) put_run(3, 8'hF5);
      put_run(1, 8'hFB);
      put_run(dd ? 256 : 128, dd ? 8'h40 : 8'hE5);
      put_run(1, 8'hF7);
      put_run(dd ? 54 : 27, gap);
    end
    put_run(dd ? 598 : 247, gap);
    fmt_idle();
  endtask
endmodule
`default_nettype wire

// [verif/disk_controller_status_and_format_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module disk_controller_status_and_format_bench;
  localparam logic [5:0] EV_MASK [6] = '{6'h03, 6'h2E, 6'h1E, 6'h0E, 6'h08, 6'h10};
  logic clk_sys_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic cmd_start_i = 1'h0;
  logic force_int_i = 1'h0;
  logic force_int_now_i = 1'h0;
  logic cmd_done_i = 1'h0;
  logic double_density_i = 1'h0;
  logic [2:0] cmd_class_i = 3'h0;
  logic [6:0] lv = 7'h40;
  logic [5:0] ev = 6'h00;
  logic cs_n_i, rd_n_i, fmt_valid_i, host_interrupt_request, fmt_mark_o, fmt_crc_write_o;
  logic [1:0] reg_sel_i;
  logic [7:0] fmt_data_i, status_o;
  logic [15:0] fmt_crc_o;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed;
  dsf_status dut_u (
    .clk_sys_i, .reset_n_i, .cs_n_i, .rd_n_i, .reg_sel_i, .cmd_start_i, .cmd_class_i, .force_int_i,
    .force_int_now_i, .cmd_done_i, .double_density_i, .drive_ready_i(lv[6]), .media_locked_n_in(lv[5]),
    .head_engage_out(lv[4]), .head_settled_in(lv[3]), .outer_track_n_in(lv[2]), .index_n_in(lv[1]),
    .byte_transfer_request(lv[0]), .verify_fail_i(ev[0]), .crc_fail_i(ev[1]), .not_found_i(ev[2]),
    .lost_data_i(ev[3]), .write_fault_i(ev[4]), .deleted_mark_i(ev[5]), .fmt_valid_i, .fmt_data_i,
    .status_o, .host_interrupt_request, .fmt_mark_o, .fmt_crc_write_o, .fmt_crc_o
  );
  dsf_host_model host_u (
    .clk_sys_i, .status_i(status_o), .crc_write_i(fmt_crc_write_o), .mark_i(fmt_mark_o), .cs_n_o(cs_n_i),
    .rd_n_o(rd_n_i),
    .reg_sel_o(reg_sel_i), .fmt_valid_o(fmt_valid_i), .fmt_data_o(fmt_data_i)
  );
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  function automatic logic [7:0] exp_st(input logic [2:0] c, input logic [5:0] f);
    case (c)
      3'h0: return {~lv[6], ~lv[5], lv[4] & lv[3], f[0], f[1], ~lv[2], ~lv[1], 1'h1};
      3'h1: return {~lv[6], 1'h0, f[5], f[2], f[1], f[3], lv[0], 1'h1};
      3'h2: return {~lv[6], ~lv[5], f[4], f[2], f[1], f[3], lv[0], 1'h1};
      3'h3: return {~lv[6], 2'h0, f[2], f[1], f[3], lv[0], 1'h1};
      3'h4: return {~lv[6], 4'h0, f[3], lv[0], 1'h1};
      default: return {~lv[6], ~lv[5], f[4], 3'h0, lv[0], 1'h1};
    endcase
  endfunction
  // A preset CRC register run over one mark byte, most significant bit first.
  function automatic logic [15:0] crc_of(input logic [7:0] b);
    logic [15:0] r;
    r = 16'hFFFF;
    for (int i = 7; i >= 0; i--) begin
      r = {r[14:0], 1'h0} ^ ((r[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    end
    return r;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic run_cmd(input logic [2:0] c, input logic abort);
    logic [5:0] e;
    logic [7:0] saved;
    int w;
    int n0;
    int m0;
    @(posedge clk_sys_i);
    cmd_start_i <= 1'h1;
    cmd_class_i <= c;
    double_density_i <= (c == 3'h5) ? abort : 1'($urandom);
    lv <= 7'($urandom);
    @(posedge clk_sys_i);
    cmd_start_i <= 1'h0;
    w = 1;
    @(negedge clk_sys_i);
    while (status_o[0] !== 1'h1 && w < 30) begin
      @(negedge clk_sys_i);
      w++;
    end
    chk("busy_delay_ok", 8'h01, {7'h00, w <= (double_density_i ? 12 : 24)});
    e = 6'($urandom) & EV_MASK[c];
    @(posedge clk_sys_i);
    ev <= e;
    @(posedge clk_sys_i);
    ev <= 6'h00;
    repeat (3) @(negedge clk_sys_i);
    chk("status_running", exp_st(c, e), status_o);
    @(posedge clk_sys_i);
    lv <= 7'($urandom);
    repeat (2) @(negedge clk_sys_i);
    chk("status_live", exp_st(c, e), status_o);
    if (c == 3'h5) begin
      n0 = host_u.n_crc;
      m0 = host_u.n_mark;
      host_u.fmt_track(double_density_i);
      repeat (2) @(negedge clk_sys_i);
      chk("crc_writes", 16'h0034, 16'(host_u.n_crc - n0));
      chk("mark_writes", double_density_i ? 16'h00D4 : 16'h0035, 16'(host_u.n_mark - m0));
      host_u.put_run(1, 8'hFB);
      host_u.fmt_idle();
      repeat (2) @(negedge clk_sys_i);
      chk("crc_after_mark", crc_of(8'hFB), fmt_crc_o);
    end
    saved = status_o;
    @(posedge clk_sys_i);
    if (abort) force_int_i <= 1'h1;
    else cmd_done_i <= 1'h1;
    @(posedge clk_sys_i);
    force_int_i <= 1'h0;
    cmd_done_i <= 1'h0;
    repeat (2) @(negedge clk_sys_i);
    if (abort) chk("status_forced", {saved[7:1], 1'h0}, status_o);
    else chk("busy_done", 8'h00, {7'h00, status_o[0]});
  endtask
  ////////////////////////////////////////
  initial begin
    seed = $urandom(32'hF9C4);
    repeat (10) @(posedge clk_sys_i);
    chk("reset_status", 8'h80, status_o);
    reset_n_i <= 1'h1;
    for (int i = 0; i < 12; i++) begin
      run_cmd(3'(i % 6), i >= 6);
    end
    // Verify and CRC events raised while idle must stay hidden in the idle type 1 layout.
    @(posedge clk_sys_i);
    lv <= 7'($urandom);
    ev <= 6'h03;
    force_int_i <= 1'h1;
    force_int_now_i <= 1'h1;
    @(posedge clk_sys_i);
    ev <= 6'h00;
    force_int_i <= 1'h0;
    force_int_now_i <= 1'h0;
    repeat (2) @(negedge clk_sys_i);
    chk("status_idle_force", exp_st(3'h0, 6'h00) & 8'hFE, status_o);
    chk("irq_set", 8'h01, {7'h00, host_interrupt_request});
    host_u.read_status();
    chk("status_read", exp_st(3'h0, 6'h00) & 8'hFE, host_u.last_read);
    repeat (2) @(negedge clk_sys_i);
    chk("irq_clear", 8'h00, {7'h00, host_interrupt_request});
    tally_and_finish();
  end
endmodule
`default_nettype wire
